// >>> design/nvmac_top.sv
// Nonvolatile byte store access controller: I/O registers, arm interlock, timing, stalls
`timescale 1ns/100ps
`include "nvmac_cfg.svh"

// How it works
// - Eight-bit address picks one of 256 bytes, linearly from zero.
// - Data register feeds programming and receives read bytes.
// - Control bits 7 and 6 are read-only zero.
// - Mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - Mode field writes ignored while program strobe is set.
// - Reset clears mode to 00 unless programming is in progress.
// - Ready interrupt raised when enabled, global enable set, and memory ready.
// - Programming starts only if strobe written within four cycles of arming.
// - Arm bit clears itself four cycles after being set.
// - Strobe write with arm clear does nothing and strobe stays clear.
// - Programming start halts the CPU for two cycles.
// - Program strobe stays set while busy, clears when time elapses.
// - Busy programming blocks flash, fuse and lock self-programming.
// - Read strobe loads the addressed byte into data register at once.
// - A read halts the CPU for four cycles, or two if a start is written with it.
// - While programming, reads refused and address register frozen.
// - Three eight-bit scratch registers, reset zero, at 0x14, 0x15 and a third.
// - Programming runs to completion even through reset.
module nvmac_top #(
    parameter int ATOMIC_CYC = `NVMAC_ATOMIC_CYC,
    parameter int SPLIT_CYC  = `NVMAC_SPLIT_CYC,
    parameter int DEPTH      = 256
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // I/O register port from the CPU core
    input  wire logic [5:0]  io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    input  wire logic        global_irq_enable,
    // To the CPU core and other programmers
    output logic             cpu_halt,
    output logic             ready_irq,
    output logic             self_prog_block,
    // Storage array port
    output logic             arr_erase,
    output logic             arr_write,
    output logic [7:0]       arr_addr,
    output logic [7:0]       arr_wdata,
    input  wire logic [7:0]  arr_rdata
);
    // --------------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------------
    // The timer is 24 bits wide; longer programming times need a wider counter
    if (DEPTH != 256) begin : g_bad_depth
        $error("nvmac_top: only a depth of 256 bytes is served");
    end
    if (ATOMIC_CYC < 1 || ATOMIC_CYC >= (1 << 24)) begin : g_bad_atomic
        $error("nvmac_top: atomic cycle count out of range");
    end
    if (SPLIT_CYC < 1 || SPLIT_CYC >= (1 << 24)) begin : g_bad_split
        $error("nvmac_top: split cycle count out of range");
    end

    localparam logic [23:0] ATOMIC_C = ATOMIC_CYC[23:0];
    localparam logic [23:0] SPLIT_C  = SPLIT_CYC[23:0];
    localparam logic [2:0]  ARM_C    = 3'(`NVMAC_ARM_CYCLES);
    localparam logic [2:0]  PHALT_C  = 3'(`NVMAC_PROG_HALT);
    localparam logic [2:0]  RHALT_C  = 3'(`NVMAC_READ_HALT);

    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    // Writes decode the full six-bit offset; all other offsets are ignored
    logic wr_ctl, wr_dat, wr_adr, wr_s0, wr_s1, wr_s2;
    assign wr_ctl = io_wr && io_addr == `NVMAC_OFF_CONTROL;
    assign wr_dat = io_wr && io_addr == `NVMAC_OFF_DATA;
    assign wr_adr = io_wr && io_addr == `NVMAC_OFF_ADDR_LOW;
    assign wr_s0  = io_wr && io_addr == `NVMAC_OFF_SCRATCH0;
    assign wr_s1  = io_wr && io_addr == `NVMAC_OFF_SCRATCH1;
    assign wr_s2  = io_wr && io_addr == `NVMAC_OFF_SCRATCH2;

    // --------------------------------------------------------------
    // Programming engine (survives reset)
    // --------------------------------------------------------------
    // Busy state, its timer, mode and the latched operands are not reset while
    // busy so that an operation started before reset finishes cleanly.
    nvmac_pkg::nvmac_state_t state_q, state_d;
    nvmac_pkg::nvmac_mode_t  mode_q, mode_d;
    logic [23:0]             timer_q, timer_d;
    logic                    erase_q, erase_d, write_q, write_d;
    logic [7:0]              paddr_q, paddr_d, pdata_q, pdata_d;
    logic                    busy;
    logic                    start;
    logic                    arm_q, arm_d;
    logic [2:0]              arm_cnt_q, arm_cnt_d;
    logic [7:0]              addr_q, addr_d, data_q, data_d;
    logic                    blk_q;

    assign busy  = state_q == nvmac_pkg::NVMAC_BUSY;
    // Mode 11 is reserved: nothing starts, strobe stays clear
    assign start = wr_ctl && io_wdata[`NVMAC_BIT_PROG] && arm_q && !busy
                   && mode_q != nvmac_pkg::NVMAC_MODE_RSVD;

    always_comb begin
        state_d = state_q;
        mode_d  = mode_q;
        timer_d = timer_q;
        erase_d = 1'b0;
        write_d = 1'b0;
        paddr_d = paddr_q;
        pdata_d = pdata_q;
        if (wr_ctl && !busy) begin
            mode_d = nvmac_pkg::nvmac_mode_t'(io_wdata[`NVMAC_BIT_MODE_HI:`NVMAC_BIT_MODE_LO]);
        end
        case (state_q)
            nvmac_pkg::NVMAC_IDLE: begin
                if (start) begin
                    state_d = nvmac_pkg::NVMAC_BUSY;
                    timer_d = (mode_q == nvmac_pkg::NVMAC_MODE_ATOMIC) ? ATOMIC_C : SPLIT_C;
                    erase_d = mode_q != nvmac_pkg::NVMAC_MODE_WRITE;
                    write_d = mode_q != nvmac_pkg::NVMAC_MODE_ERASE;
                    paddr_d = addr_q;
                    pdata_d = data_q;
                end
            end
            nvmac_pkg::NVMAC_BUSY: begin
                // Ending at one makes a load of N give exactly N busy cycles
                if (timer_q <= 24'h000001) begin
                    state_d = nvmac_pkg::NVMAC_IDLE;
                    timer_d = 24'h000000;
                end else begin
                    timer_d = timer_q - 24'h000001;
                end
            end
            default: state_d = nvmac_pkg::NVMAC_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // Reset survivors
    // --------------------------------------------------------------
    // Array strobes and the block flag ignore reset too: a reset in the cycle
    // after a start must not swallow the erase or write pulse, and other
    // programmers stay locked out until the timer runs out.
    always_ff @(posedge clock) begin
        erase_q <= erase_d;
        write_q <= write_d;
        blk_q   <= state_d == nvmac_pkg::NVMAC_BUSY;
    end

    // Not reset at all: keeps an operation running through reset
    always_ff @(posedge clock) begin
        state_q <= state_d;
        timer_q <= timer_d;
        paddr_q <= paddr_d;
        pdata_q <= pdata_d;
    end

    // Mode clears on reset only when idle; applied synchronously while held,
    // because the busy test is no constant that an async branch could load
    always_ff @(posedge clock) begin
        if (!rst_n && !busy) begin
            mode_q <= nvmac_pkg::NVMAC_MODE_ATOMIC;
        end else begin
            mode_q <= mode_d;
        end
    end

    // --------------------------------------------------------------
    // Arm interlock, address, data, scratch, halt
    // --------------------------------------------------------------
    logic [7:0] s0_q, s0_d, s1_q, s1_d, s2_q, s2_d;
    logic       rie_q, rie_d;
    logic [2:0] halt_q, halt_d;
    logic       rd_go;

    // The array is tied up while programming, so reads are refused then
    assign rd_go = wr_ctl && io_wdata[`NVMAC_BIT_READ] && !busy;

    always_comb begin
        arm_d     = arm_q;
        arm_cnt_d = arm_cnt_q;
        addr_d    = addr_q;
        data_d    = data_q;
        s0_d      = wr_s0 ? io_wdata : s0_q;
        s1_d      = wr_s1 ? io_wdata : s1_q;
        s2_d      = wr_s2 ? io_wdata : s2_q;
        rie_d     = wr_ctl ? io_wdata[`NVMAC_BIT_RIE] : rie_q;
        // Stall counts down to zero; the core waits while it is non-zero
        halt_d    = (halt_q != 3'h0) ? halt_q - 3'h1 : 3'h0;
        // Re-arming while armed does not stretch the four-cycle window
        if (arm_q) begin
            if (arm_cnt_q >= ARM_C - 3'h1) begin
                arm_d     = 1'b0;
                arm_cnt_d = 3'h0;
            end else begin
                arm_cnt_d = arm_cnt_q + 3'h1;
            end
        end else if (wr_ctl && io_wdata[`NVMAC_BIT_ARM]) begin
            arm_d     = 1'b1;
            arm_cnt_d = 3'h0;
        end
        if (wr_adr && !busy) begin
            addr_d = io_wdata;
        end
        if (wr_dat) begin
            data_d = io_wdata;
        end
        if (rd_go) begin
            data_d = arr_rdata;
            halt_d = RHALT_C;
        end
        // A start written together with a read strobe takes the program stall
        if (start) begin
            halt_d = PHALT_C;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'h0;
            addr_q    <= `NVMAC_RST_BYTE;
            data_q    <= `NVMAC_RST_BYTE;
            s0_q      <= `NVMAC_RST_BYTE;
            s1_q      <= `NVMAC_RST_BYTE;
            s2_q      <= `NVMAC_RST_BYTE;
            rie_q     <= 1'b0;
            halt_q    <= 3'h0;
        end else begin
            arm_q     <= arm_d;
            arm_cnt_q <= arm_cnt_d;
            addr_q    <= addr_d;
            data_q    <= data_d;
            s0_q      <= s0_d;
            s1_q      <= s1_d;
            s2_q      <= s2_d;
            rie_q     <= rie_d;
            halt_q    <= halt_d;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    logic [7:0] rdata_d;
    logic       halt_o_d, irq_d;

    always_comb begin
        // Unread cycles return zero so the core may OR several read buses
        case (io_addr)
            `NVMAC_OFF_CONTROL: rdata_d = {2'b00, mode_q, rie_q, arm_q, busy, 1'b0};
            `NVMAC_OFF_DATA:     rdata_d = data_q;
            `NVMAC_OFF_ADDR_LOW: rdata_d = addr_q;
            `NVMAC_OFF_SCRATCH0: rdata_d = s0_q;
            `NVMAC_OFF_SCRATCH1: rdata_d = s1_q;
            `NVMAC_OFF_SCRATCH2: rdata_d = s2_q;
            default:             rdata_d = 8'h00;
        endcase
        if (!io_rd) begin
            rdata_d = 8'h00;
        end
        halt_o_d = halt_d != 3'h0;
        // Next-state values, so the request drops in the cycle the block flag rises
        irq_d    = rie_d && global_irq_enable && (state_d == nvmac_pkg::NVMAC_IDLE);
    end

    // --------------------------------------------------------------
    // Output registers
    // --------------------------------------------------------------
    logic [7:0] rdata_q;
    logic       halt_o_q, irq_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= 8'h00;
            halt_o_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            halt_o_q <= halt_o_d;
            irq_q    <= irq_d;
        end
    end

    // --------------------------------------------------------------
    // Port drive
    // --------------------------------------------------------------
    assign io_rdata        = rdata_q;
    assign cpu_halt        = halt_o_q;
    assign ready_irq       = irq_q;
    assign self_prog_block = blk_q;
    assign arr_erase       = erase_q;
    assign arr_write       = write_q;
    assign arr_addr        = paddr_q;
    assign arr_wdata       = pdata_q;
endmodule // nvmac_top

// >>> design/nvmac_cfg.svh
// Offsets, field positions, reset values and timing figures of the nvm access controller
`ifndef NVMAC_CFG_SVH
`define NVMAC_CFG_SVH
`define NVMAC_OFF_SCRATCH0   6'h14
`define NVMAC_OFF_SCRATCH1   6'h15
`define NVMAC_OFF_SCRATCH2   6'h16
`define NVMAC_OFF_CONTROL    6'h1c
`define NVMAC_OFF_DATA       6'h1d
`define NVMAC_OFF_ADDR_LOW   6'h1e
`define NVMAC_BIT_READ       0
`define NVMAC_BIT_PROG       1
`define NVMAC_BIT_ARM        2
`define NVMAC_BIT_RIE        3
`define NVMAC_BIT_MODE_LO    4
`define NVMAC_BIT_MODE_HI    5
`define NVMAC_RST_BYTE       8'h00
`define NVMAC_CLK_KHZ        50000
`define NVMAC_T_ATOMIC_US    3400
`define NVMAC_T_SPLIT_US     1800
`define NVMAC_ARM_CYCLES     4
`define NVMAC_PROG_HALT      2
`define NVMAC_READ_HALT      4
`define NVMAC_ATOMIC_CYC     ((`NVMAC_T_ATOMIC_US * `NVMAC_CLK_KHZ) / 1000)
`define NVMAC_SPLIT_CYC      ((`NVMAC_T_SPLIT_US * `NVMAC_CLK_KHZ) / 1000)
`endif

// >>> design/nvmac_pkg.sv
// Types of the nvm access controller
package nvmac_pkg;
    typedef enum logic [1:0] {
        NVMAC_MODE_ATOMIC,
        NVMAC_MODE_ERASE,
        NVMAC_MODE_WRITE,
        NVMAC_MODE_RSVD
    } nvmac_mode_t;
    typedef enum logic [1:0] {
        NVMAC_IDLE,
        NVMAC_BUSY
    } nvmac_state_t;
endpackage

// >>> tb/nvmac_chk.sv
// Port checker of the nvm access controller
`timescale 1ns/100ps
`include "nvmac_cfg.svh"
module nvmac_chk #(
    parameter int ATOMIC_CYC = 40,
    parameter int SPLIT_CYC  = 30
) (
    // Watched ports
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [5:0] io_addr,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       global_irq_enable,
    input wire logic       cpu_halt,
    input wire logic       ready_irq,
    input wire logic       self_prog_block,
    input wire logic       arr_erase,
    input wire logic       arr_write
);
    logic       ctl_wr;
    logic       start;
    logic [2:0] arm_q;
    logic [2:0] arm_d;
    int         busy_q;
    assign ctl_wr = io_wr && io_addr == `NVMAC_OFF_CONTROL;
    assign start  = arr_erase || arr_write;
    always_comb begin
        arm_d = (arm_q != 3'h0) ? arm_q - 3'h1 : 3'h0;
        if (ctl_wr && io_wdata[`NVMAC_BIT_ARM]) begin
            arm_d = 3'(`NVMAC_ARM_CYCLES);
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arm_q <= 3'h0;
        end else begin
            arm_q <= arm_d;
        end
    end
    // Busy length counts through reset, as programming survives it
    always_ff @(posedge clock) begin
        busy_q <= self_prog_block ? busy_q + 1 : 0;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence halt_two;
        cpu_halt ##1 cpu_halt ##1 !cpu_halt;
    endsequence
    sequence halt_four;
        cpu_halt [*4] ##1 !cpu_halt;
    endsequence
    chk_ctl_top_zero: assert property (
        io_rd && io_addr == `NVMAC_OFF_CONTROL |=> io_rdata[7:6] == 2'b00)
        else $error("control top bits not zero");
    chk_prog_halt: assert property (start |-> halt_two)
        else $error("program stall not two cycles");
    chk_read_halt: assert property (
        ctl_wr && io_wdata[`NVMAC_BIT_READ] && !self_prog_block && !cpu_halt |=> halt_four)
        else $error("read stall not four cycles");
    chk_start_blocks: assert property (start |-> self_prog_block)
        else $error("self programming not blocked");
    chk_unarmed_start: assert property (
        ctl_wr && io_wdata[`NVMAC_BIT_PROG] && arm_q == 3'h0 |=> !start)
        else $error("start without arm");
    chk_busy_length: assert property (
        $fell(self_prog_block) |-> busy_q inside {ATOMIC_CYC, SPLIT_CYC})
        else $error("busy length wrong");
    chk_irq_busy: assert property (self_prog_block |-> !ready_irq)
        else $error("ready irq while busy");
    chk_irq_global: assert property (!global_irq_enable |=> !ready_irq)
        else $error("ready irq while masked");
    chk_busy_read: assert property (
        self_prog_block && !cpu_halt && ctl_wr && io_wdata[`NVMAC_BIT_READ] |=> !cpu_halt)
        else $error("read taken while busy");
endmodule // nvmac_chk

// >>> tb/nvmac_arr_model.sv
// Behavioural byte array behind the controller
`timescale 1ns/100ps
module nvmac_arr_model (
    // Controller side
    input  wire logic       clock,
    input  wire logic       arr_erase,
    input  wire logic       arr_write,
    input  wire logic [7:0] arr_addr,
    input  wire logic [7:0] arr_wdata,
    input  wire logic [7:0] rd_addr,
    output logic [7:0]      arr_rdata
);
    logic [7:0] mem [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    // Write-only just clears bits, so an unerased byte is corrupted
    always @(posedge clock) begin
        if (arr_erase) begin
            mem[arr_addr] <= arr_write ? arr_wdata : 8'hff;
        end else if (arr_write) begin
            mem[arr_addr] <= mem[arr_addr] & arr_wdata;
        end
    end
    assign arr_rdata = mem[rd_addr];
endmodule // nvmac_arr_model

// >>> tb/nvmac_top_test.sv
// Self-checking bench of the nvm access controller
`timescale 1ns/100ps
`include "nvmac_cfg.svh"
module nvmac_top_test;
    localparam logic [5:0] CTL = `NVMAC_OFF_CONTROL;
    localparam logic [5:0] DAT = `NVMAC_OFF_DATA;
    localparam logic [5:0] ADR = `NVMAC_OFF_ADDR_LOW;
    logic       clock = 0, rst_n = 0, io_wr = 0, io_rd = 0, global_irq_enable = 1;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, addr_sh = 8'h00, v, io_rdata, arr_addr, arr_wdata, arr_rdata;
    logic       cpu_halt, ready_irq, self_prog_block, arr_erase, arr_write;
    int         n_errors = 0, num_checks = 0;
    logic [7:0] rows [7][3] = '{'{8'h14, 8'ha5, 8'ha5}, '{8'h15, 8'h5a, 8'h5a},
        '{8'h16, 8'h3c, 8'h3c}, '{8'h1d, 8'h96, 8'h96}, '{8'h1e, 8'h07, 8'h07},
        '{8'h1c, 8'hf8, 8'h38}, '{8'h1c, 8'hc8, 8'h08}};
    logic [7:0] ops [3][3] = '{'{8'h0, 8'hc3, 8'hc3}, '{8'h1, 8'h00, 8'hff}, '{8'h2, 8'h3c, 8'h3c}};
    nvmac_top #(.ATOMIC_CYC(40), .SPLIT_CYC(30)) dut (.clock, .rst_n, .io_addr, .io_wr, .io_rd,
        .io_wdata, .io_rdata, .global_irq_enable, .cpu_halt, .ready_irq, .self_prog_block,
        .arr_erase, .arr_write, .arr_addr, .arr_wdata, .arr_rdata);
    nvmac_arr_model u_arr (.clock, .arr_erase, .arr_write, .arr_addr, .arr_wdata,
        .rd_addr(addr_sh), .arr_rdata);
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // The bench plays the core, so it stalls while the halt is up
    task automatic go();
        do begin
            @(posedge clock);
            #1;
        end while (cpu_halt === 1'b1);
    endtask
    task automatic wr(logic [5:0] a, logic [7:0] d);
        go();
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        if (a == ADR && self_prog_block !== 1'b1) addr_sh = d;
        @(posedge clock);
        #1 io_wr = 1'b0;
    endtask
    task automatic rd(logic [5:0] a, output logic [7:0] q);
        go();
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clock);
        #1 io_rd = 1'b0;
        q = io_rdata;
    endtask
    task automatic reset_dut();
        rst_n = 1'b0;
        repeat (6) @(posedge clock);
        #1 rst_n = 1'b1;
    endtask
    // Polls the program strobe bit, as software must before a read
    task automatic wait_idle();
        logic [7:0] c;
        c = 8'h02;
        repeat (100) begin
            rd(CTL, c);
            if (c[`NVMAC_BIT_PROG] == 1'b0) break;
        end
        chk("idle", {7'h0, self_prog_block}, 8'h00);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #80000;
        n_errors++;
        finish_test();
    end
    initial begin
        reset_dut();
        foreach (rows[i]) begin
            wr(rows[i][0][5:0], rows[i][1]);
            rd(rows[i][0][5:0], v);
            chk("register", v, rows[i][2]);
        end
        $display("registers done");
        reset_dut();
        foreach (rows[i]) begin
            rd(rows[i][0][5:0], v);
            if (i != 4) chk("reset value", v, 8'h00);
        end
        $display("reset done");
        wr(ADR, 8'h10);
        wr(CTL, 8'h01);
        rd(DAT, v);
        chk("read byte", v, 8'h4a);
        foreach (ops[i]) begin
            wr(CTL, {2'b00, ops[i][0][1:0], 4'h8});
            wr(DAT, ops[i][1]);
            wr(CTL, {2'b00, ops[i][0][1:0], 4'hc});
            wr(CTL, {2'b00, ops[i][0][1:0], 4'ha});
            chk("busy", {7'h0, self_prog_block}, 8'h01);
            wr(CTL, 8'h38);
            wr(ADR, 8'h20);
            wr(CTL, 8'h09);
            rd(CTL, v);
            chk("busy control", v & 8'h3a, {2'b00, ops[i][0][1:0], 4'ha});
            wait_idle();
            rd(CTL, v);
            chk("done control", v, {2'b00, ops[i][0][1:0], 4'h8});
            chk("ready irq", {7'h0, ready_irq}, 8'h01);
            rd(ADR, v);
            chk("frozen address", v, 8'h10);
            wr(CTL, {2'b00, ops[i][0][1:0], 4'h9});
            rd(DAT, v);
            chk("programmed byte", v, ops[i][2]);
        end
        $display("programming done");
        wr(CTL, 8'h04);
        repeat (5) @(posedge clock);
        wr(CTL, 8'h02);
        rd(CTL, v);
        chk("late strobe", v, 8'h00);
        wr(CTL, 8'h30);
        wr(CTL, 8'h34);
        wr(CTL, 8'h32);
        rd(CTL, v);
        chk("reserved mode", v & 8'h3a, 8'h30);
        wr(CTL, 8'h10);
        wr(CTL, 8'h14);
        wr(CTL, 8'h12);
        reset_dut();
        rd(CTL, v);
        chk("kept mode", v, 8'h12);
        wait_idle();
        wr(ADR, 8'h10);
        wr(CTL, 8'h01);
        rd(DAT, v);
        chk("erased", v, 8'hff);
        wr(CTL, 8'h08);
        global_irq_enable = 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("masked irq", {7'h0, ready_irq}, 8'h00);
        $display("awkward cases done");
        finish_test();
    end
endmodule // nvmac_top_test
bind nvmac_top nvmac_chk #(.ATOMIC_CYC(ATOMIC_CYC), .SPLIT_CYC(SPLIT_CYC)) u_chk (.clock, .rst_n,
    .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .global_irq_enable, .cpu_halt, .ready_irq,
    .self_prog_block, .arr_erase, .arr_write);
